// *** rtl/stp_pkg.sv ***
// constants, field layout and pixel carrier of the test pattern generator
// assumes one 125 MHz clock and register offsets as seen on the serial port
`default_nettype none
package stp_pkg;
    localparam int REG_COUNT = 8;
    localparam logic [6:0] ADDR_RESERVED_A = 7'h36;
    localparam logic [6:0] ADDR_RESERVED_B = 7'h37;
    localparam logic [6:0] ADDR_CONTROL = 7'h38;
    localparam logic [6:0] ADDR_FIXED_HIGH = 7'h39;
    localparam logic [6:0] ADDR_FIXED_LOW = 7'h3a;
    localparam logic [6:0] ADDR_PITCH = 7'h3b;
    localparam logic [6:0] ADDR_STEP = 7'h3c;
    localparam logic [6:0] ADDR_DELAY = 7'h3d;
    localparam logic [6:0] ADDR_LAST = 7'h3f;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int BIT_OUT_SELECT = 7;
    localparam int BIT_KIND_HI = 6;
    localparam int BIT_KIND_LO = 5;
    localparam int BIT_COLOR_HI = 4;
    localparam int BIT_COLOR_LO = 3;
    localparam int FRAME_BITS = 16;
    localparam logic [9:0] FULL_SCALE = 10'h3ff;
    typedef enum logic [1:0] {
        KIND_FIXED,
        KIND_MAIN_GRAD,
        KIND_SUB_GRAD,
        KIND_GRID
    } stp_kind_t;
    typedef struct packed {
        logic [9:0] red;
        logic [9:0] green;
        logic [9:0] blue;
    } stp_pix_t;
endpackage : stp_pkg
`default_nettype wire

// *** rtl/stp_top.sv ***
// test pattern generator with its serial register port
// assumes pixel data and valid come from logic on CLK; serial pins and
// line pulses are asynchronous and are synchronised here
`default_nettype none
module stp_top
    import stp_pkg::*;
(
    input wire logic CLK, // sampling clock
    input wire logic RESET_N, // async reset
    input wire logic SERIAL_SELECT_N, // serial frame select
    input wire logic SCLK, // serial clock pin
    input wire logic SERIAL_IN, // serial data from host
    output logic SERIAL_OUT, // serial read data
    input wire logic LINE_CLAMP_PULSE, // once per line
    input wire logic BLACK_WINDOW_PULSE, // start of black pixels
    input wire stp_pix_t PIX_IN, // converted pixels
    input wire logic PIX_IN_VALID, // converted pixel strobe
    output stp_pix_t PIX_OUT, // pixels to downstream
    output logic PIX_OUT_VALID // output pixel strobe
);
    // pin synchronisers, stage three is only an edge reference
    logic [2:0] sel_sync_reg, sclk_sync_reg, sdi_sync_reg;
    logic [2:0] clamp_sync_reg, bwin_sync_reg;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sel_sync_reg <= 3'h7;
            sclk_sync_reg <= 3'h0;
            sdi_sync_reg <= 3'h0;
            clamp_sync_reg <= 3'h0;
            bwin_sync_reg <= 3'h0;
        end else begin
            sel_sync_reg <= {sel_sync_reg[1:0], SERIAL_SELECT_N};
            sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK};
            sdi_sync_reg <= {sdi_sync_reg[1:0], SERIAL_IN};
            clamp_sync_reg <= {clamp_sync_reg[1:0], LINE_CLAMP_PULSE};
            bwin_sync_reg <= {bwin_sync_reg[1:0], BLACK_WINDOW_PULSE};
        end
    end
    wire sel_act = ~sel_sync_reg[1];
    wire sdi_s = sdi_sync_reg[1];
    wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    wire line_edge = clamp_sync_reg[1] & ~clamp_sync_reg[2];
    wire bwin_edge = bwin_sync_reg[1] & ~bwin_sync_reg[2];

    // serial frame: r/w bit (1 = read), 7-bit address, 8 data bits, msb first
    logic [15:0] shift_in_reg;
    logic [4:0] bit_cnt_reg;
    logic [7:0] out_shift_reg;
    logic sdo_reg;
    logic [7:0] reg_mem [REG_COUNT];
    wire [6:0] rd_addr = {shift_in_reg[5:0], sdi_s};
    wire rd_req = sel_act & sclk_rise & (bit_cnt_reg == 5'd7) &
                  shift_in_reg[6];
    wire [6:0] wr_addr = shift_in_reg[13:7];
    wire [7:0] wr_data = {shift_in_reg[6:0], sdi_s};
    wire wr_req = sel_act & sclk_rise & (bit_cnt_reg == 5'd15) &
                  ~shift_in_reg[14];

    function automatic logic in_map(input logic [6:0] a);
        return (a >= ADDR_RESERVED_A) && (a <= ADDR_DELAY);
    endfunction : in_map

    // unmapped and trailing reserved offsets read zero
    wire [7:0] rd_data = in_map(rd_addr) ?
                         reg_mem[3'(rd_addr - ADDR_RESERVED_A)] : 8'h00;
    wire [2:0] wr_idx = 3'(wr_addr - ADDR_RESERVED_A);

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            shift_in_reg <= 16'h0000;
            bit_cnt_reg <= 5'd0;
        end else if (!sel_act) begin
            bit_cnt_reg <= 5'd0;
        end else if (sclk_rise && bit_cnt_reg != 5'(FRAME_BITS)) begin
            shift_in_reg <= {shift_in_reg[14:0], sdi_s};
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_shift_reg <= 8'h00;
            sdo_reg <= 1'b0;
        end else if (!sel_act) begin
            out_shift_reg <= 8'h00;
            sdo_reg <= 1'b0;
        end else if (rd_req) begin
            out_shift_reg <= rd_data;
        end else if (sclk_fall) begin
            sdo_reg <= out_shift_reg[7];
            out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        end
    end
    assign SERIAL_OUT = sdo_reg;

    // leading reserved words 0x36 and 0x37 are kept writable; the host is trusted to leave them
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < REG_COUNT; i++) reg_mem[i] <= RESET_VALUE;
        end else if (wr_req && in_map(wr_addr)) begin
            reg_mem[wr_idx] <= wr_data;
        end
    end

    wire [7:0] ctl = reg_mem[3'(ADDR_CONTROL - ADDR_RESERVED_A)];
    wire pat_on = ctl[BIT_OUT_SELECT];
    wire [1:0] kind = ctl[BIT_KIND_HI:BIT_KIND_LO];
    wire [1:0] color_sel = ctl[BIT_COLOR_HI:BIT_COLOR_LO];
    wire [9:0] fixed_code = {reg_mem[3'(ADDR_FIXED_HIGH - ADDR_RESERVED_A)],
        reg_mem[3'(ADDR_FIXED_LOW - ADDR_RESERVED_A)][7:6]};
    wire [7:0] pitch = reg_mem[3'(ADDR_PITCH - ADDR_RESERVED_A)];
    wire [7:0] step = reg_mem[3'(ADDR_STEP - ADDR_RESERVED_A)];
    wire [3:0] delay = reg_mem[3'(ADDR_DELAY - ADDR_RESERVED_A)][3:0];
    // a pitch of zero behaves as one, so the pattern never freezes
    wire [7:0] pitch_last = (pitch == 8'h00) ? 8'h00 : pitch - 8'h01;

    function automatic logic [17:0] advance(input logic [7:0] cnt,
                                            input logic [9:0] code,
                                            input logic [7:0] last,
                                            input logic [7:0] inc);
        if (cnt >= last) return {8'h00, 10'(code + {2'b00, inc})};
        return {8'(cnt + 8'h01), code};
    endfunction : advance

    // pixel position restarts at the black window and at each line
    logic [7:0] pix_pitch_reg;
    logic [9:0] pix_code_reg;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pix_pitch_reg <= 8'h00;
            pix_code_reg <= 10'h000;
        end else if (line_edge || bwin_edge) begin
            pix_pitch_reg <= 8'h00;
            pix_code_reg <= 10'h000;
        end else if (PIX_IN_VALID) begin
            {pix_pitch_reg, pix_code_reg} <=
                advance(pix_pitch_reg, pix_code_reg, pitch_last, step);
        end
    end

    // lines since pattern enable, saturating past the largest stagger
    logic [5:0] line_cnt_reg;
    logic [7:0] ln_pitch_reg [3];
    logic [9:0] ln_code_reg [3];
    logic [2:0] started;
    always_comb begin
        for (int c = 0; c < 3; c++)
            started[c] = line_cnt_reg >= 6'(c * delay);
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            line_cnt_reg <= 6'd0;
        end else if (!pat_on) begin
            line_cnt_reg <= 6'd0;
        end else if (line_edge && line_cnt_reg != 6'h3f) begin
            line_cnt_reg <= line_cnt_reg + 6'd1;
        end
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int c = 0; c < 3; c++) begin
                ln_pitch_reg[c] <= 8'h00;
                ln_code_reg[c] <= 10'h000;
            end
        end else begin
            for (int c = 0; c < 3; c++) begin
                if (!pat_on || !started[c]) begin
                    ln_pitch_reg[c] <= 8'h00;
                    ln_code_reg[c] <= 10'h000;
                end else if (line_edge) begin
                    {ln_pitch_reg[c], ln_code_reg[c]} <= advance(
                        ln_pitch_reg[c], ln_code_reg[c], pitch_last, step);
                end
            end
        end
    end

    // per colour pattern value; colour 0 red, 1 green, 2 blue
    logic [9:0] pat [3];
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            case (stp_kind_t'(kind))
                KIND_FIXED: pat[c] = fixed_code;
                KIND_MAIN_GRAD: pat[c] = pix_code_reg;
                KIND_SUB_GRAD: pat[c] = ln_code_reg[c];
                KIND_GRID: pat[c] = (pix_pitch_reg == 8'h00 ||
                    ln_pitch_reg[c] == 8'h00) ? FULL_SCALE : fixed_code;
                default: pat[c] = fixed_code;
            endcase
            if ((color_sel != 2'b00 && color_sel != 2'(c + 1)) ||
                !started[c])
                pat[c] = FULL_SCALE;
        end
    end
    wire stp_pix_t pat_pix = '{red: pat[0], green: pat[1], blue: pat[2]};

    stp_pix_t pix_out_reg;
    logic pix_valid_reg;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pix_out_reg <= '0;
            pix_valid_reg <= 1'b0;
        end else begin
            pix_valid_reg <= PIX_IN_VALID;
            if (PIX_IN_VALID) pix_out_reg <= pat_on ? pat_pix : PIX_IN;
        end
    end
    assign PIX_OUT = pix_out_reg;
    assign PIX_OUT_VALID = pix_valid_reg;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_normal_pass: assert property (
        PIX_IN_VALID && !pat_on |=> PIX_OUT == $past(PIX_IN))
        else $error("normal data lost");
    a_fixed_code: assert property (
        PIX_IN_VALID && pat_on && kind == 2'b00 && color_sel == 2'b00 &&
        delay == 4'h0 |=> PIX_OUT.red == $past(fixed_code))
        else $error("bad fixed");
    a_color_masked: assert property (
        PIX_IN_VALID && pat_on && color_sel == 2'b01 |=>
        PIX_OUT.green == FULL_SCALE && PIX_OUT.blue == FULL_SCALE)
        else $error("mask fail");
    a_fixed_bits: assert property (
        wr_req && wr_addr == ADDR_FIXED_LOW |=>
        fixed_code[1:0] == $past(wr_data[7:6]) &&
        fixed_code[9:2] == $past(fixed_code[9:2]))
        else $error("fixed low bits");
    a_grad_step: assert property (
        PIX_IN_VALID && !line_edge && !bwin_edge &&
        pix_pitch_reg >= pitch_last |=>
        pix_code_reg == 10'($past(pix_code_reg) + $past(step)))
        else $error("step wrong");
    a_grad_hold: assert property (
        PIX_IN_VALID && !line_edge && !bwin_edge &&
        pix_pitch_reg < pitch_last |=> $stable(pix_code_reg))
        else $error("early step");
    a_line_origin: assert property (
        line_edge |=> pix_code_reg == 10'h000 && pix_pitch_reg == 8'h00)
        else $error("no origin");
    // a delay raised mid-run may leave one stale code cycle, so look next
    a_stagger: assert property (
        pat_on && delay != 4'h0 && line_cnt_reg < 6'(delay) |->
        pat[1] == FULL_SCALE ##1 ln_code_reg[1] == 10'h000)
        else $error("green early");
    a_grid_line: assert property (
        pat_on && kind == 2'b11 && started[0] && ln_pitch_reg[0] == 8'h00 &&
        color_sel == 2'b00 |-> pat[0] == FULL_SCALE)
        else $error("grid line");
    a_serial_write: assert property (
        wr_req && wr_addr == ADDR_STEP |=> step == $past(wr_data))
        else $error("write lost");
    c_read_frame: cover property (rd_req ##[1:200] sclk_fall);
    c_grid_on: cover property (pat_on && kind == 2'b11 && PIX_IN_VALID);
    c_sub_grad: cover property (pat_on && kind == 2'b10 && line_edge);
endmodule : stp_top
`default_nettype wire

// *** tb/scan_test_pattern_generator_tb.sv ***
// self-checking bench: serial register traffic and pattern checks
// assumes stp_top and the sink model; one 125 MHz clock
`default_nettype none
module scan_test_pattern_generator_tb import stp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, sel_n = 1, sck = 0, sin = 0;
    logic lcp = 0, bwp = 0, vin = 0;
    logic sout, vout;
    stp_pix_t pin = '0, pout, got;
    int unsigned n_got;
    int n_fail = 0, total_checks = 0;
    int n_sent = 0;
    stp_pix_t exp_q [$];
    logic [7:0] mreg [8] = '{default: 8'h00}; // offsets 0x36..0x3d
    always #4 clk = ~clk;
    stp_top uut (.CLK(clk), .RESET_N(rst_n), .SERIAL_SELECT_N(sel_n),
        .SCLK(sck), .SERIAL_IN(sin), .SERIAL_OUT(sout),
        .LINE_CLAMP_PULSE(lcp), .BLACK_WINDOW_PULSE(bwp), .PIX_IN(pin),
        .PIX_IN_VALID(vin), .PIX_OUT(pout), .PIX_OUT_VALID(vout));
    stp_sink sink (.clk(clk), .rst_n(rst_n), .pix(pout), .pix_valid(vout),
        .last_pix(got), .n_taken(n_got));
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [29:0] g, input logic [29:0] e,
                       input string what);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                g, e);
        end
    endtask : chk
    // slow serial clock: each level 5 cycles, above the sync needs
    task automatic ser(input logic rd, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, d};
        q = '0;
        sel_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sck <= 1'b0;
            sin <= f[i];
            repeat (5) @(posedge clk);
            if (i < 8) q = {q[6:0], sout};
            sck <= 1'b1;
            repeat (5) @(posedge clk);
        end
        sck <= 1'b0;
        repeat (5) @(posedge clk);
        sel_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : ser
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        ser(1'b0, a, d, q);
        if (a < 7'h3e) mreg[a - 7'h36] = d;
    endtask : wr
    // n: pixels since the last line origin, ln: line edges since enable
    task automatic pix(input int n, input int ln);
        stp_pix_t v, e;
        int code, p, lc;
        logic [9:0] lvl [3];
        v = stp_pix_t'(30'($urandom));
        e = v;
        p = (mreg[5] == 8'h00) ? 1 : int'(mreg[5]);
        for (int c = 0; c < 3; c++) begin
            lc = ln - c * int'(mreg[7][3:0]);
            case (mreg[2][6:5])
                2'd1: code = ((n / p) * int'(mreg[6])) % 1024;
                2'd2: code = ((lc / p) * int'(mreg[6])) % 1024;
                2'd3: code = (n % p == 0 || lc % p == 0) ? 1023 :
                    int'({mreg[3], mreg[4][7:6]});
                default: code = int'({mreg[3], mreg[4][7:6]});
            endcase
            lvl[c] = ((mreg[2][4:3] != 0 && mreg[2][4:3] != c + 1)
                || lc < 0) ? 10'h3ff : 10'(code);
        end
        if (mreg[2][7]) e = {lvl[0], lvl[1], lvl[2]};
        exp_q.push_back(e);
        n_sent++;
        pin <= v;
        vin <= 1'b1;
        @(posedge clk);
        vin <= 1'b0;
        // sink takes it at the second edge; read once that has settled
        repeat (3) @(posedge clk);
        chk(got, exp_q.pop_front(), "pixel");
        chk(30'(n_got), 30'(n_sent), "strobe count");
    endtask : pix
    task automatic line(input logic bw);
        if (bw) bwp <= 1'b1;
        else lcp <= 1'b1;
        repeat (3) @(posedge clk);
        bwp <= 1'b0;
        lcp <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : line
    initial begin
        logic [7:0] q;
        logic [7:0] want;
        q = 8'($urandom(32'h64c0));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int a = 'h36; a <= 'h3f; a++) begin
            ser(1'b1, 7'(a), 8'h00, q);
            chk(30'(q), 30'h0, "reset value");
        end
        for (int a = 'h38; a <= 'h3e; a++) begin
            wr(7'(a), 8'($urandom));
            ser(1'b1, 7'(a), 8'h00, q);
            want = (a < 'h3e) ? mreg[a - 'h36] : 8'h00;
            chk(30'(q), 30'(want), "read");
        end
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_DELAY, 8'h00);
        repeat (4) pix(0, 99);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_FIXED_HIGH, 8'($urandom));
            wr(ADDR_FIXED_LOW, 8'($urandom));
            wr(ADDR_CONTROL, 8'(8'h80 | (s << 3)));
            pix(0, 99);
        end
        wr(ADDR_PITCH, 8'($urandom_range(3)));
        wr(ADDR_STEP, 8'($urandom));
        wr(ADDR_CONTROL, 8'ha0);
        for (int l = 0; l < 2; l++) begin
            line(l[0]);
            for (int n = 0; n < 9; n++) begin
                pix(n, 99);
            end
        end
        wr(ADDR_DELAY, 8'hf1);
        // pitch above one so the grid shows both levels
        wr(ADDR_PITCH, 8'($urandom_range(3, 2)));
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_CONTROL, 8'(8'h80 | (k << 5)));
            line(1'b1);
            for (int ln = 0; ln < 8; ln++) begin
                for (int n = 0; n < 3; n++) pix(n, ln);
                line(1'b0);
            end
        end
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule : scan_test_pattern_generator_tb
`default_nettype wire

// *** tb/stp_sink.sv ***
// downstream pixel receiver: keeps the last pixel taken and a strobe count
// assumes PIX_OUT means something only while PIX_OUT_VALID is high
`default_nettype none
module stp_sink
    import stp_pkg::*;
(
    input wire logic clk, // sampling clock
    input wire logic rst_n, // async reset
    input wire stp_pix_t pix, // pixel from generator
    input wire logic pix_valid, // one-cycle strobe
    output stp_pix_t last_pix, // last pixel taken
    output int unsigned n_taken // strobes seen
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_pix <= '0;
            n_taken <= 0;
        end else if (pix_valid) begin
            last_pix <= pix;
            n_taken <= n_taken + 1;
        end
    end
endmodule : stp_sink
`default_nettype wire
